// file: verilog/oscillator_select_control.sv
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module oscillator_select_control
   import osc_ctrl_pkg::*;
#(
   parameter int LP_LIMIT = LP_FAIL_CYCLES,
   parameter int MAIN_LIMIT = MAIN_FAIL_CYCLES
) (
   input wire logic clk_sys, // system clock, 20 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic [ADDR_W-1:0] avs_address, // byte address
   input wire logic avs_read, // read strobe
   input wire logic avs_write, // write strobe
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // byte lanes
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   input wire logic [7:0] flashTrim, // trim from option bits
   input wire logic lowPowerOscClk, // low-power osc, sampled
   input wire logic mainOscClk, // primary osc, sampled
   output logic [7:0] rcTrim, // RC oscillator trim
   output osc_enables_t oscEnables, // oscillator enables
   output sys_clk_source_sel_t sysClkSourceSel, // active source
   output logic oscFailEvent, // non-maskable failure event
   output logic irq // level interrupt
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   lock_state_t lock_r;
   logic [7:0] ctrl_r;
   logic [7:0] trim_r;
   logic trimLoaded_r;
   logic [EV_W-1:0] status_r;
   logic [EV_W-1:0] ien_r;
   logic forced_r;
   logic ack_r;
   logic [1:0] lpSync_r;
   logic [1:0] mainSync_r;
   logic lpFail;
   logic mainFail;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [11:0] idx);
      hit = (a == ADDR_W'({idx, 2'b00}));
   endfunction

   function automatic logic legalSrc(input logic [2:0] s);
      legalSrc = (s == SRC_RC_FAST) || (s == SRC_RC_SLOW) ||
                 (s == SRC_LOW_POWER) || (s == SRC_EXT_PIN);
   endfunction

   logic wrStb;
   logic ctrlWr;
   logic [7:0] wByte;
   assign wrStb = avs_write && !ack_r && avs_byteenable[0];
   assign ctrlWr = wrStb && hit(avs_address, CTRL_INDEX);
   assign wByte = avs_writedata[7:0];

   // ------------------------------------------------------------
   // bus handshake: every access answered one cycle after it starts
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read || avs_write) && !ack_r;
      end
   end

   // waitrequest must fall in the answer cycle, so it is a flop cleared
   // by the start of an access and raised again after the answer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
      end
   end

   // ------------------------------------------------------------
   // oscillator synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lpSync_r <= 2'b00;
         mainSync_r <= 2'b00;
      end else begin
         lpSync_r <= {lpSync_r[0], lowPowerOscClk};
         mainSync_r <= {mainSync_r[0], mainOscClk};
      end
   end

   // ------------------------------------------------------------
   // unlock sequence
   // ------------------------------------------------------------
   // writes elsewhere leave the sequence alone
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lock_r <= LOCKED; // R18
      end else if (ctrlWr) begin
         case (lock_r)
            LOCKED: lock_r <= (wByte == UNLOCK_FIRST) ?
                              HALF_OPEN : LOCKED; // R1
            HALF_OPEN: lock_r <= (wByte == UNLOCK_SECOND) ?
                                 OPEN : LOCKED; // R1 R3
            OPEN: lock_r <= LOCKED; // R2
            default: lock_r <= LOCKED;
         endcase
      end
   end

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RESET; // R18
      end else if (ctrlWr && lock_r == OPEN) begin
         // reserved bit 6 masked to zero
         ctrl_r[7:3] <= wByte[7:3] & CTRL_WMASK[7:3]; // R5 R4 R6 R7 R8
         if (legalSrc(wByte[2:0])) begin
            ctrl_r[2:0] <= wByte[2:0]; // R13
         end
      end
   end

   // ------------------------------------------------------------
   // failure detectors
   // ------------------------------------------------------------
   edge_watchdog #(.LIMIT(LP_LIMIT)) lpWatch (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .armed(ctrl_r[LP_FD_BIT] && ctrl_r[LP_ON_BIT] &&
             sysClkSourceSel != SRC_LOW_POWER), // R8
      .oscSync(lpSync_r[1]),
      .failPulse(lpFail)
   );

   edge_watchdog #(.LIMIT(MAIN_LIMIT)) mainWatch (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .armed(ctrl_r[MAIN_FD_BIT] && !forced_r &&
             !status_r[EV_LP_FAIL]), // R7
      .oscSync(mainSync_r[1]),
      .failPulse(mainFail)
   );

   // recovery needs a live low-power oscillator not already in use
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         forced_r <= 1'b0;
      end else if (ctrlWr && lock_r == OPEN) begin
         forced_r <= 1'b0;
      end else if (mainFail && ctrl_r[LP_ON_BIT] &&
                   ctrl_r[2:0] != SRC_LOW_POWER) begin
         forced_r <= 1'b1; // R16
      end
   end

   // ------------------------------------------------------------
   // source select and enables out
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sysClkSourceSel <= SRC_RC_FAST; // R18
         oscEnables <= '0;
      end else begin
         sysClkSourceSel <= forced_r ? SRC_LOW_POWER : // R16
            sys_clk_source_sel_t'(ctrl_r[2:0]); // R9 R10 R11 R12
         oscEnables.fastRcOscOn <= ctrl_r[FAST_RC_BIT]; // R4
         oscEnables.lowPowerOscOn <= ctrl_r[LP_ON_BIT]; // R6
         oscEnables.mainOscFailDetectOn <= ctrl_r[MAIN_FD_BIT]; // R7
         oscEnables.lowPowerOscFailDetectOn <= ctrl_r[LP_FD_BIT]; // R8
      end
   end

   // ------------------------------------------------------------
   // trim register
   // ------------------------------------------------------------
   // flash value taken on the first clock after reset release
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         trim_r <= 8'h00;
         trimLoaded_r <= 1'b0;
      end else if (!trimLoaded_r) begin
         trim_r <= flashTrim; // R15
         trimLoaded_r <= 1'b1;
      end else if (wrStb && hit(avs_address, TRIM_INDEX)) begin
         trim_r <= wByte; // R14 R15
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rcTrim <= 8'h00;
      end else begin
         rcTrim <= trim_r; // R14
      end
   end

   // ------------------------------------------------------------
   // events and interrupt
   // ------------------------------------------------------------
   logic [EV_W-1:0] evNow;
   assign evNow = {lpFail, mainFail};

   // a new event wins over a clear in the same cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         status_r <= '0;
         ien_r <= '0;
      end else begin
         if (wrStb && hit(avs_address, CLR_INDEX)) begin
            status_r <= (status_r & ~wByte[EV_W-1:0]) | evNow;
         end else begin
            status_r <= status_r | evNow;
         end
         if (wrStb && hit(avs_address, IEN_INDEX)) begin
            ien_r <= wByte[EV_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
         oscFailEvent <= 1'b0;
      end else begin
         irq <= |((status_r | evNow) & ien_r);
         oscFailEvent <= |evNow; // R16
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack_r) begin
         if (hit(avs_address, CTRL_INDEX)) begin
            avs_readdata <= {24'h000000, ctrl_r}; // R5
         end else if (hit(avs_address, TRIM_INDEX)) begin
            avs_readdata <= {24'h000000, trim_r};
         end else if (hit(avs_address, STAT_INDEX)) begin
            avs_readdata <= {30'h0, status_r};
         end else if (hit(avs_address, IEN_INDEX)) begin
            avs_readdata <= {30'h0, ien_r};
         end else if (hit(avs_address, SRC_INDEX)) begin
            avs_readdata <= {29'h0, sysClkSourceSel};
         end else begin
            avs_readdata <= 32'h0000_0000; // unmapped reads zero
         end
      end
   end
endmodule

// file: verilog/osc_ctrl_pkg.sv
// Notes on behaviour
// R1 - unlock needs a write of E7 then a write of 18 to the control register
// R2 - one update write after unlocking relocks the register
// R3 - stray control writes are ignored; other registers may interleave
// R4 - bit 7 enables the fast RC oscillator; never cleared by a source change
// R5 - bit 6 is reserved; software writes 0 and it reads back 0
// R6 - bit 5 enables the low-power oscillator
// R7 - bit 4 enables primary oscillator failure detection and recovery
// R8 - bit 3 enables low-power oscillator failure detection
// R9 - source code 000 selects the RC oscillator in fast mode
// R10 - source code 001 selects the RC oscillator in slow mode
// R11 - source code 011 selects the low-power oscillator
// R12 - source code 100 selects the external clock pin
// R13 - reserved source codes leave the current source unchanged
// R14 - an 8-bit trim register sets the RC oscillator frequency
// R15 - trim loads from flash option bits by default; software may override
// R16 - primary failure with recovery on forces low-power source, raises event; the code switches only while bit 5 has the low-power oscillator on
// R17 - low-power failure declared after 8004 clocks with no oscillator edge
// R18 - reset: RC and low-power on, detection off, fast RC chosen, locked; the oscEnables outputs stay all off until the first clock after reset
package osc_ctrl_pkg;
   // ------------------------------------------------------------
   // register map (byte address is the index times four)
   // ------------------------------------------------------------
   localparam logic [11:0] CTRL_INDEX = 12'hF86;
   localparam logic [11:0] TRIM_INDEX = 12'hF87;
   localparam logic [11:0] STAT_INDEX = 12'hF88;
   localparam logic [11:0] CLR_INDEX = 12'hF89;
   localparam logic [11:0] IEN_INDEX = 12'hF8A;
   localparam logic [11:0] SRC_INDEX = 12'hF8B;
   localparam int ADDR_W = 14;
   localparam logic [7:0] UNLOCK_FIRST = 8'hE7;
   localparam logic [7:0] UNLOCK_SECOND = 8'h18;
   localparam logic [7:0] CTRL_RESET = 8'hA0;
   localparam logic [7:0] CTRL_WMASK = 8'hBF;
   localparam int FAST_RC_BIT = 7;
   localparam int LP_ON_BIT = 5;
   localparam int MAIN_FD_BIT = 4;
   localparam int LP_FD_BIT = 3;
   localparam int EV_MAIN_FAIL = 0;
   localparam int EV_LP_FAIL = 1;
   localparam int EV_W = 2;
   localparam int LP_FAIL_CYCLES = 8004;
   localparam int MAIN_FAIL_CYCLES = 8004;

   typedef enum logic [2:0] {
      SRC_RC_FAST = 3'h0,
      SRC_RC_SLOW = 3'h1,
      SRC_LOW_POWER = 3'h3,
      SRC_EXT_PIN = 3'h4
   } sys_clk_source_sel_t;

   typedef enum {LOCKED, HALF_OPEN, OPEN} lock_state_t;

   typedef struct packed {
      logic fastRcOscOn;
      logic lowPowerOscOn;
      logic mainOscFailDetectOn;
      logic lowPowerOscFailDetectOn;
   } osc_enables_t;
endpackage

// file: verilog/edge_watchdog.sv
`timescale 1ns/1ps
// counts clocks without a seen edge on a sampled oscillator
module edge_watchdog
   import osc_ctrl_pkg::*;
#(
   parameter int LIMIT = LP_FAIL_CYCLES
) (
   input wire logic clk_sys, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic armed, // detection enabled
   input wire logic oscSync, // synchronised oscillator level
   output logic failPulse // one-cycle failure event
);
   logic [13:0] count_r;
   logic prevLevel_r;
   logic tripped_r;

   // ------------------------------------------------------------
   // edge search
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= 14'h0000;
         prevLevel_r <= 1'b0;
         tripped_r <= 1'b0;
         failPulse <= 1'b0;
      end else begin
         prevLevel_r <= oscSync;
         failPulse <= 1'b0;
         if (!armed || (oscSync != prevLevel_r)) begin
            count_r <= 14'h0000;
            tripped_r <= 1'b0;
         end else if (!tripped_r) begin
            // one event per outage; re-arms on the next edge
            if (count_r == 14'(LIMIT - 1)) begin // R17
               failPulse <= 1'b1;
               tripped_r <= 1'b1;
            end else begin
               count_r <= count_r + 14'h0001;
            end
         end
      end
   end
endmodule

// file: verif/oscillator_select_control_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// port-level checks
// ----------------------------------------
module osc_select_props
   import osc_ctrl_pkg::*;
#(
   parameter int LP_LIMIT = LP_FAIL_CYCLES,
   parameter int MAIN_LIMIT = MAIN_FAIL_CYCLES
) (
   input wire logic clk_sys, // system clock
   input wire logic rst_n, // async reset
   input wire logic [ADDR_W-1:0] avs_address, // byte address
   input wire logic avs_read, // read strobe
   input wire logic avs_write, // write strobe
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // lanes
   input wire logic [31:0] avs_readdata, // read data
   input wire logic avs_waitrequest, // stall
   input wire logic lowPowerOscClk, // low-power osc
   input wire logic mainOscClk, // primary osc
   input wire osc_enables_t oscEnables, // enables
   input wire sys_clk_source_sel_t sysClkSourceSel, // source
   input wire logic oscFailEvent // failure pulse
);
   logic [1:0] lockSt_r;
   logic rdy1_r, rdy_r, lpLast_r, mainLast_r;
   logic [15:0] lpQuiet_r, mainQuiet_r;
   logic ctrlAck, updAck;
   logic [7:0] wd;
   logic [3:0] wdEn;
   logic [2:0] wdSrc;
   logic wdLegal;
   assign wd = avs_writedata[7:0];
   assign wdEn = {wd[7], wd[5:3]};
   assign wdSrc = wd[2:0];
   assign wdLegal = wdSrc inside {SRC_RC_FAST, SRC_RC_SLOW, SRC_LOW_POWER,
      SRC_EXT_PIN};
   assign ctrlAck = !avs_waitrequest && avs_write && avs_byteenable[0]
      && avs_address == {CTRL_INDEX, 2'b00};
   assign updAck = ctrlAck && lockSt_r == 2'h2;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // lock model advanced at each answered control write
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) lockSt_r <= 2'h0;
      else if (ctrlAck) lockSt_r <= (lockSt_r == 2'h0 && wd == UNLOCK_FIRST)
         ? 2'h1 : (lockSt_r == 2'h1 && wd == UNLOCK_SECOND) ? 2'h2 : 2'h0;
   end
   // skip the reset-load edge, where outputs move without a write
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) {rdy1_r, rdy_r} <= 2'h0;
      else {rdy1_r, rdy_r} <= {1'b1, rdy1_r};
   end
   // raw quiet time is never shorter than the synced count
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) {lpQuiet_r, mainQuiet_r, lpLast_r, mainLast_r} <= '0;
      else begin
         lpLast_r <= lowPowerOscClk;
         mainLast_r <= mainOscClk;
         lpQuiet_r <= (lowPowerOscClk != lpLast_r) ? 16'h0 : lpQuiet_r + 16'h1;
         mainQuiet_r <= (mainOscClk != mainLast_r) ? 16'h0 :
            mainQuiet_r + 16'h1;
      end
   end
   property p_ack;
      (avs_read || avs_write) && avs_waitrequest && $past(avs_waitrequest)
         |=> !avs_waitrequest;
   endproperty
   a_ack: assert property (p_ack) else $error("no answer after one wait");
   property p_ackone;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_ackone: assert property (p_ackone) else $error("answer held too long");
   property p_rsv;
      !avs_waitrequest && avs_read && avs_address == {CTRL_INDEX, 2'b00}
         |-> !avs_readdata[6];
   endproperty
   a_rsv: assert property (p_rsv)
      else $error("reserved bit read as one");
   // register outputs move one edge after the answered update write
   property p_lock;
      rdy_r && $changed(oscEnables) |-> $past(updAck);
   endproperty
   a_lock: assert property (p_lock)
      else $error("enables moved while locked");
   property p_upd;
      updAck |=> oscEnables == $past(wdEn);
   endproperty
   a_upd: assert property (p_upd)
      else $error("enables differ from write");
   property p_src;
      updAck && wdLegal |=> sysClkSourceSel == $past(wdSrc);
   endproperty
   a_src: assert property (p_src)
      else $error("source differs from write");
   property p_rsvsrc;
      updAck && !wdLegal |=> $stable(sysClkSourceSel);
   endproperty
   a_rsvsrc: assert property (p_rsvsrc)
      else $error("reserved code moved source");
   property p_recover;
      rdy_r && $changed(sysClkSourceSel)
         |-> $past(updAck) || sysClkSourceSel == SRC_LOW_POWER;
   endproperty
   a_recover: assert property (p_recover)
      else $error("source moved unasked");
   property p_early;
      oscFailEvent |-> lpQuiet_r >= LP_LIMIT || mainQuiet_r >= MAIN_LIMIT;
   endproperty
   a_early: assert property (p_early)
      else $error("failure declared too early");
   property p_pulse;
      oscFailEvent |=> !oscFailEvent;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("failure event too long");
endmodule

bind oscillator_select_control osc_select_props #(.LP_LIMIT(LP_LIMIT),
   .MAIN_LIMIT(MAIN_LIMIT)) osc_select_props_inst (.clk_sys(clk_sys),
   .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .lowPowerOscClk(lowPowerOscClk),
   .mainOscClk(mainOscClk), .oscEnables(oscEnables),
   .sysClkSourceSel(sysClkSourceSel), .oscFailEvent(oscFailEvent));

// file: verif/oscillator_select_control_tb_top.sv
`timescale 1ns/1ps
module oscillator_select_control_tb_top
   import osc_ctrl_pkg::*;
;
   logic clk_sys = 0, rst_n = 0, avs_read = 0, avs_write = 0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata;
   logic [3:0] avs_byteenable = 4'hF;
   logic [7:0] flashTrim = 8'h3C, rcTrim, d[5];
   logic lowPowerOscClk = 0, mainOscClk = 0, lpRun = 1, mainRun = 1;
   logic avs_waitrequest, oscFailEvent, irq;
   osc_enables_t oscEnables;
   sys_clk_source_sel_t sysClkSourceSel, s[5];
   int errors = 0, comparisons = 0, n;
   oscillator_select_control #(.LP_LIMIT(16), .MAIN_LIMIT(16))
      oscillator_select_control_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .flashTrim(flashTrim), .lowPowerOscClk(lowPowerOscClk),
      .mainOscClk(mainOscClk), .rcTrim(rcTrim), .oscEnables(oscEnables),
      .sysClkSourceSel(sysClkSourceSel), .oscFailEvent(oscFailEvent),
      .irq(irq));
   // ----------------------------------------
   // clock and oscillators
   // ----------------------------------------
   always #25 clk_sys = ~clk_sys;
   // a stopped oscillator freezes its level, which the detectors must catch
   always @(posedge clk_sys) begin
      if (lpRun) lowPowerOscClk <= ~lowPowerOscClk;
      if (mainRun) mainOscClk <= ~mainOscClk;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // request held until waitrequest is sampled low, one edge idle after
   task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] v,
      output logic [7:0] q);
      int k;
      k = 0;
      avs_address <= {i, 2'b00};
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, v};
      do begin
         @(posedge clk_sys);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      if (k >= 50) chk("waitrequest", 0, 1);
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [11:0] i, input logic [7:0] v);
      logic [7:0] q;
      bus(1'b1, i, v, q);
   endtask
   task automatic rdchk(input string nm, input logic [11:0] i,
      input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, i, 8'h0, q);
      chk(nm, e, q);
   endtask
   task automatic upd(input logic [7:0] v);
      wr(CTRL_INDEX, UNLOCK_FIRST);
      wr(CTRL_INDEX, UNLOCK_SECOND);
      wr(CTRL_INDEX, v);
   endtask
   task automatic waitEv();
      n = 0;
      while (oscFailEvent !== 1'b1 && n < 400) begin
         @(posedge clk_sys);
         n++;
      end
      chk("fail event", 1, oscFailEvent);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      rdchk("ctrl", CTRL_INDEX, CTRL_RESET);
      chk("source", SRC_RC_FAST, sysClkSourceSel);
      chk("enables", 4'hC, oscEnables);
      rdchk("trim", TRIM_INDEX, 8'h3C);
      chk("rcTrim", 8'h3C, rcTrim);
      rdchk("unmapped", 12'hF90, 8'h00);
   endtask
   task automatic t_lock();
      wr(CTRL_INDEX, 8'h00);
      rdchk("locked ctrl", CTRL_INDEX, CTRL_RESET);
      wr(CTRL_INDEX, UNLOCK_FIRST);
      rdchk("trim between", TRIM_INDEX, 8'h3C);
      wr(CTRL_INDEX, UNLOCK_SECOND);
      wr(CTRL_INDEX, 8'h21);
      chk("source", SRC_RC_SLOW, sysClkSourceSel);
      chk("enables", 4'h4, oscEnables);
      wr(CTRL_INDEX, 8'hA4);
      rdchk("relocked ctrl", CTRL_INDEX, 8'h21);
      wr(CTRL_INDEX, UNLOCK_FIRST);
      wr(CTRL_INDEX, 8'h19);
      wr(CTRL_INDEX, 8'hA3);
      chk("bad unlock", SRC_RC_SLOW, sysClkSourceSel);
   endtask
   task automatic t_sources();
      d = '{8'hA3, 8'h84, 8'h82, 8'h01, 8'hA0};
      s = '{SRC_LOW_POWER, SRC_EXT_PIN, SRC_EXT_PIN, SRC_RC_SLOW, SRC_RC_FAST};
      for (int i = 0; i < 5; i++) begin
         upd(d[i]);
         chk("source", s[i], sysClkSourceSel);
         chk("enables", {d[i][7], d[i][5:3]}, oscEnables);
      end
   endtask
   task automatic t_trim();
      wr(TRIM_INDEX, 8'h5A);
      rdchk("trim", TRIM_INDEX, 8'h5A);
      chk("rcTrim", 8'h5A, rcTrim);
      // lane 0 off: the write must be dropped
      avs_byteenable <= 4'hE;
      wr(TRIM_INDEX, 8'hA5);
      avs_byteenable <= 4'hF;
      rdchk("lane off", TRIM_INDEX, 8'h5A);
   endtask
   task automatic t_main_fail();
      wr(IEN_INDEX, 8'h03);
      upd(8'hB0);
      mainRun <= 1'b0;
      waitEv();
      rdchk("status", STAT_INDEX, 8'h01);
      chk("forced source", SRC_LOW_POWER, sysClkSourceSel);
      chk("irq", 1, irq);
      wr(IEN_INDEX, 8'h00);
      chk("irq masked", 0, irq);
      wr(IEN_INDEX, 8'h03);
      chk("irq unmasked", 1, irq);
      upd(8'hA0);
      chk("source", SRC_RC_FAST, sysClkSourceSel);
      mainRun <= 1'b1;
      wr(CLR_INDEX, 8'h01);
      rdchk("status", STAT_INDEX, 8'h00);
      chk("irq cleared", 0, irq);
   endtask
   task automatic t_lp_fail();
      upd(8'hA8);
      lpRun <= 1'b0;
      waitEv();
      chk("lp wait", 1, n >= 16);
      rdchk("status", STAT_INDEX, 8'h02);
      chk("no switch", SRC_RC_FAST, sysClkSourceSel);
      upd(8'hA0);
      lpRun <= 1'b1;
      wr(CLR_INDEX, 8'h02);
      rdchk("status", STAT_INDEX, 8'h00);
   endtask
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic complete_run();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // the whole sequence needs well under a thousand cycles
   initial begin
      #2000000;
      errors++;
      complete_run();
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      t_reset();
      t_lock();
      t_sources();
      t_trim();
      t_main_fail();
      t_lp_fail();
      complete_run();
   end
endmodule
